// *** hw/port_power_map.svh ***
`ifndef PORT_POWER_MAP_SVH
`define PORT_POWER_MAP_SVH

`define PPC_PORTS 6
`define PPC_ADDR_W 4
`define PPC_ADDR_CTRL 4'h0
`define PPC_ADDR_STATUS 4'h4
`define PPC_ADDR_MASK 4'h8
`define PPC_ADDR_LIVE 4'hc
`define PPC_CTRL_SPLIT_BIT 6
`define PPC_CTRL_SS_LSB 8
`define PPC_LIVE_PIN_LSB 8
`define PPC_CFG_EN_RESET 6'h3f
`define PPC_SS_EN_RESET 6'h00
`define PPC_MASK_RESET 6'h00
`define PPC_SETTLE_CYCLES 2'h3

`endif

// *** hw/port_power_pkg.sv ***
package port_power_pkg;
    typedef logic [5:0] port_vec_t;
    typedef enum {SEL_CTRL, SEL_STATUS, SEL_MASK, SEL_LIVE, SEL_NONE} reg_sel_t;
endpackage

// *** hw/pin_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 6
) (
    input wire logic clk, // core clock
    input wire logic rst, // async reset, active high
    input wire logic ce, // clock enable
    input wire logic [WIDTH-1:0] d, // raw pin levels
    output logic [WIDTH-1:0] q // synchronised levels
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_q;

    always_comb
    begin
        next_meta = ce ? d : meta;
        next_q = ce ? meta : q;
    end

    // idle level of a released pin is high
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta <= '1;
            q <= '1;
        end
        else
        begin
            meta <= next_meta;
            q <= next_q;
        end
    end
endmodule
`default_nettype wire

// *** hw/port_power_overcurrent_ctl.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "port_power_map.svh"
module port_power_overcurrent_ctl #(
    parameter int PORTS = `PPC_PORTS
) (
    input wire logic clk, // 20 MHz core clock
    input wire logic rst, // async reset, active high
    input wire logic ce, // clock enable, freezes state when low
    input wire logic [`PPC_ADDR_W-1:0] addr, // register byte address
    input wire logic [31:0] wdata, // register write data
    input wire logic wr_stb, // write strobe
    input wire logic rd_stb, // read strobe
    output logic [31:0] rdata, // read data, cycle after rd_stb
    input wire port_power_pkg::port_vec_t host_port_enable, // hub logic port power state
    input wire port_power_pkg::port_vec_t port_power_sense_in, // pin level, bit i = port i+1
    output port_power_pkg::port_vec_t port_power_sense_out, // pin drive value
    output port_power_pkg::port_vec_t port_power_sense_oe, // pin driven when high
    output port_power_pkg::port_vec_t pullup_en, // internal pull-up on
    output port_power_pkg::port_vec_t usb2_power_on, // usb 2.0 portion powered
    output port_power_pkg::port_vec_t usb3_power_on, // usb 3.2 portion powered
    output port_power_pkg::port_vec_t usb2_oc, // overcurrent to usb 2.0 portion
    output port_power_pkg::port_vec_t usb3_oc, // overcurrent to usb 3.2 portion
    output logic port3_superspeed_power_enable, // split usb 3.2 enable, port 3
    output logic port4_superspeed_power_enable, // split usb 3.2 enable, port 4
    output logic port5_superspeed_power_enable, // split usb 3.2 enable, port 5
    output logic irq // level interrupt
);
    import port_power_pkg::*;

    port_vec_t cfg_en;
    port_vec_t ss_en;
    logic split_port_mode;
    port_vec_t oc_status;
    port_vec_t oc_mask;
    port_vec_t sense_sync;
    logic [1:0] settle [PORTS];

    port_vec_t next_cfg_en;
    port_vec_t next_ss_en;
    logic next_split;
    port_vec_t next_status;
    port_vec_t next_mask;
    logic [1:0] next_settle [PORTS];
    logic [31:0] next_rdata;
    port_vec_t next_oe;
    port_vec_t next_pullup;
    port_vec_t next_usb2_power;
    port_vec_t next_usb3_power;
    port_vec_t next_usb2_oc;
    port_vec_t next_usb3_oc;
    logic [2:0] next_ss_pins;
    logic next_irq;

    port_vec_t port_on;
    port_vec_t settled;
    port_vec_t oc_now;
    port_vec_t w1c;
    reg_sel_t sel;

    function automatic reg_sel_t decode(input logic [`PPC_ADDR_W-1:0] a);
        case (a)
            `PPC_ADDR_CTRL: decode = SEL_CTRL;
            `PPC_ADDR_STATUS: decode = SEL_STATUS;
            `PPC_ADDR_MASK: decode = SEL_MASK;
            `PPC_ADDR_LIVE: decode = SEL_LIVE;
            default: decode = SEL_NONE;
        endcase
    endfunction

    pin_sync #(.WIDTH(PORTS)) u_sense_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .d(port_power_sense_in),
        .q(sense_sync)
    );

    always_comb
    begin
        sel = decode(addr);
        next_cfg_en = cfg_en;
        next_ss_en = ss_en;
        next_split = split_port_mode;
        next_mask = oc_mask;
        w1c = '0;
        if (wr_stb)
        begin
            case (sel)
                SEL_CTRL:
                begin
                    next_cfg_en = wdata[5:0];
                    next_split = wdata[`PPC_CTRL_SPLIT_BIT];
                    next_ss_en = wdata[`PPC_CTRL_SS_LSB +: 6];
                end
                SEL_STATUS: w1c = wdata[5:0];
                SEL_MASK: next_mask = wdata[5:0];
                default: ;
            endcase
        end
        // a port is on only if both configuration and host control allow it
        port_on = cfg_en & host_port_enable;
        // blank sensing until the released pin has had time to rise through the synchroniser
        for (int i = 0; i < PORTS; i++)
        begin
            settled[i] = (settle[i] == `PPC_SETTLE_CYCLES);
            if (!port_on[i])
                next_settle[i] = 2'h0;
            else if (!settled[i])
                next_settle[i] = settle[i] + 2'h1;
            else
                next_settle[i] = settle[i];
        end
        oc_now = port_on & settled & ~sense_sync;
        next_status = (oc_status & ~w1c) | oc_now;
        next_irq = |(next_status & next_mask);
        next_rdata = 32'h0;
        if (rd_stb)
        begin
            case (sel)
                SEL_CTRL: next_rdata = {18'h0, ss_en, 1'b0, split_port_mode, cfg_en};
                SEL_STATUS: next_rdata = {26'h0, oc_status};
                SEL_MASK: next_rdata = {26'h0, oc_mask};
                SEL_LIVE: next_rdata = {18'h0, sense_sync, 2'h0, port_on};
                default: next_rdata = 32'h0;
            endcase
        end
        next_oe = ~port_on;
        next_pullup = port_on;
        next_usb2_power = port_on;
        next_usb2_oc = oc_now;
        // port 6 always spans both portions; ports 1 to 5 split off usb 3.2 in split mode
        if (split_port_mode)
        begin
            next_usb3_power = {port_on[5], ss_en[4:0]};
            next_usb3_oc = {oc_now[5], 5'h00};
            next_ss_pins = ss_en[4:2];
        end
        else
        begin
            next_usb3_power = port_on;
            next_usb3_oc = oc_now;
            next_ss_pins = 3'h0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cfg_en <= `PPC_CFG_EN_RESET;
            ss_en <= `PPC_SS_EN_RESET;
            split_port_mode <= 1'b0;
            oc_status <= '0;
            oc_mask <= `PPC_MASK_RESET;
            for (int i = 0; i < PORTS; i++)
                settle[i] <= 2'h0;
            rdata <= 32'h0;
            port_power_sense_out <= '0;
            port_power_sense_oe <= '1;
            pullup_en <= '0;
            usb2_power_on <= '0;
            usb3_power_on <= '0;
            usb2_oc <= '0;
            usb3_oc <= '0;
            port3_superspeed_power_enable <= 1'b0;
            port4_superspeed_power_enable <= 1'b0;
            port5_superspeed_power_enable <= 1'b0;
            irq <= 1'b0;
        end
        else if (ce)
        begin
            cfg_en <= next_cfg_en;
            ss_en <= next_ss_en;
            split_port_mode <= next_split;
            oc_status <= next_status;
            oc_mask <= next_mask;
            for (int i = 0; i < PORTS; i++)
                settle[i] <= next_settle[i];
            rdata <= next_rdata;
            port_power_sense_out <= '0;
            port_power_sense_oe <= next_oe;
            pullup_en <= next_pullup;
            usb2_power_on <= next_usb2_power;
            usb3_power_on <= next_usb3_power;
            usb2_oc <= next_usb2_oc;
            usb3_oc <= next_usb3_oc;
            port3_superspeed_power_enable <= next_ss_pins[0];
            port4_superspeed_power_enable <= next_ss_pins[1];
            port5_superspeed_power_enable <= next_ss_pins[2];
            irq <= next_irq;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_low_held;
        (ce && port_on[0] && !port_power_sense_in[0]) [*6];
    endsequence

    sequence s_oc_seen;
        ce && oc_now != 6'h00;
    endsequence

    a_pin_drive_low: assert property (ce |=> port_power_sense_oe == ~$past(port_on)
        && port_power_sense_out == 6'h00)
        else $error("disabled port pin not driven low");
    a_pullup_on: assert property (ce |=> pullup_en == $past(port_on)
        && (pullup_en & port_power_sense_oe) == 6'h00)
        else $error("pull-up does not follow port enable");
    a_oc_gated: assert property (ce |=> (usb2_oc & ~$past(port_on)) == 6'h00)
        else $error("overcurrent reported on a disabled port");
    a_sense_to_flag: assert property (s_low_held |-> ##[0:2] oc_status[0])
        else $error("held low pin never latched a flag");
    a_flag_sticky: assert property (s_oc_seen |=> (oc_status & $past(oc_now)) == $past(oc_now))
        else $error("overcurrent event lost");
    a_port6_both: assert property (ce |=> usb3_oc[5] == usb2_oc[5]
        && usb3_power_on[5] == usb2_power_on[5])
        else $error("port 6 portions differ");
    a_split_usb3: assert property (ce && !split_port_mode |=> usb3_power_on == usb2_power_on
        && usb3_oc == usb2_oc)
        else $error("usb 3.2 portion not governed by pin");
    a_ss_idle: assert property (ce && !split_port_mode |=> !port3_superspeed_power_enable
        && !port4_superspeed_power_enable && !port5_superspeed_power_enable)
        else $error("split enable driven outside split mode");
    a_irq_level: assert property (ce |=> irq == |(oc_status & oc_mask))
        else $error("interrupt does not follow masked status");
endmodule
`default_nettype wire

// *** tb/port_power_partner.sv ***
`timescale 1ns/1ns
`default_nettype none
module port_power_partner (
    input wire logic clk, // core clock
    input wire port_power_pkg::port_vec_t drv_oe, // device drives pin
    input wire port_power_pkg::port_vec_t drv_val, // device drive level
    input wire port_power_pkg::port_vec_t pull_on, // device pull-up on
    input wire port_power_pkg::port_vec_t fault, // overcurrent per port
    output var port_power_pkg::port_vec_t pin // resolved pin level
);
    import port_power_pkg::*;
    port_vec_t wander = 6'h15;
    // an undriven pin without pull-up keeps changing
    always_ff @(posedge clk)
        wander <= ~wander;
    always_comb
        for (int i = 0; i < 6; i++)
            if (drv_oe[i]) pin[i] = drv_val[i];
            else if (fault[i]) pin[i] = 1'b0;
            else if (pull_on[i]) pin[i] = 1'b1;
            else pin[i] = wander[i];
endmodule
`default_nettype wire

// *** tb/test_port_power_overcurrent_ctl.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "port_power_map.svh"
module test_port_power_overcurrent_ctl;
    import port_power_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    port_vec_t host_en = 6'h00, fault = 6'h00;
    port_vec_t pin, oe, out, pu, p2, p3, oc2, oc3, on, ss, ocx;
    logic ss3, ss4, ss5, irq;
    int err_total = 0;
    int cmp_count = 0;
    int unsigned seed = 65;
    int cfg, split, mask, stat, clr;
    port_power_overcurrent_ctl u_port_power_overcurrent_ctl (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .host_port_enable(host_en),
        .port_power_sense_in(pin), .port_power_sense_out(out), .port_power_sense_oe(oe), .pullup_en(pu),
        .usb2_power_on(p2), .usb3_power_on(p3), .usb2_oc(oc2), .usb3_oc(oc3),
        .port3_superspeed_power_enable(ss3), .port4_superspeed_power_enable(ss4),
        .port5_superspeed_power_enable(ss5), .irq(irq));
    port_power_partner u_port_power_partner (.clk(clk), .drv_oe(oe), .drv_val(out), .pull_on(pu),
        .fault(fault), .pin(pin));
    initial
    begin
        forever #25 clk = ~clk;
    end
    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic finish_test();
        if (err_total == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        @(negedge clk);
        chk(rdata, exp);
        @(negedge clk);
        chk(rdata, 32'h0);
    endtask
    // pin-side outputs against the model, sampled mid-cycle
    task automatic chk_pins();
        ocx = fault & on;
        chk(oe, 6'(~on));
        chk(out, 6'h00);
        chk(pu, on);
        chk(p2, on);
        chk(p3, split ? {on[5], ss[4:0]} : on);
        chk({ss5, ss4, ss3}, split ? ss[4:2] : 3'h0);
        chk(oc2, ocx);
        chk(oc3, split ? {ocx[5], 5'h00} : ocx);
        chk(irq, 1'((stat & mask) != 0));
    endtask
    initial
    begin
        stat = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(`PPC_ADDR_CTRL, 32'h3f);
        rd(`PPC_ADDR_MASK, 32'h0);
        rd(4'h2, 32'h0);
        // a write to an unmapped address must leave the control word alone
        wr(4'h2, 32'hffffffff);
        rd(`PPC_ADDR_CTRL, 32'h3f);
        for (int it = 0; it < 40; it++)
        begin
            cfg = rnd() & 32'h3f;
            split = rnd() & 32'h1;
            ss = 6'(rnd());
            mask = rnd() & 32'h3f;
            wr(`PPC_ADDR_CTRL, {18'h0, ss, 1'b0, split[0], cfg[5:0]});
            wr(`PPC_ADDR_MASK, 32'(mask));
            host_en <= 6'(rnd());
            @(posedge clk);
            on = host_en & cfg[5:0];
            repeat (8) @(posedge clk);
            @(negedge clk);
            chk_pins();
            // clock enable low: a host change must not reach the frozen outputs
            @(posedge clk);
            ce <= 1'b0;
            host_en <= ~host_en;
            repeat (4) @(posedge clk);
            @(negedge clk);
            chk_pins();
            @(posedge clk);
            ce <= 1'b1;
            host_en <= ~host_en;
            @(posedge clk);
            fault <= 6'(rnd());
            repeat (6) @(posedge clk);
            stat |= fault & on;
            @(negedge clk);
            chk_pins();
            rd(`PPC_ADDR_LIVE, {18'h0, ~fault & on, 2'h0, on});
            rd(`PPC_ADDR_STATUS, 32'(stat));
            @(posedge clk);
            fault <= 6'h00;
            repeat (4) @(posedge clk);
            clr = rnd() & 32'h3f;
            wr(`PPC_ADDR_STATUS, 32'(clr));
            stat &= ~clr;
            rd(`PPC_ADDR_STATUS, 32'(stat));
        end
        finish_test();
    end
    initial
    begin
        #300000;
        err_total++;
        finish_test();
    end
endmodule
`default_nettype wire
